// ---- hw/ccd_timing_pkg.sv ----
// Shared constants for the CCD readout timing generator.
package ccd_timing_pkg;

    // ******************************************************************
    // Clock and sensor timing
    // ******************************************************************
    localparam int CLK_NS = 10;
    localparam int T_H_NS = 25;
    localparam int T_FD_NS = 75;
    localparam int T_PD_NS = 300;
    localparam int T_VERTICAL_SHIFT_REGISTER_NS = 200;
    localparam int T_HD_NS = 200;
    localparam int T_FDP_NS = 200;

    localparam int TMR_W = 8;
    localparam logic [TMR_W-1:0] H_HALF_CYC =
        TMR_W'((T_H_NS + 2 * CLK_NS - 1) / (2 * CLK_NS));
    localparam logic [TMR_W-1:0] FD_CYC =
        TMR_W'((T_FD_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [TMR_W-1:0] PD_CYC =
        TMR_W'((T_PD_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [TMR_W-1:0] VERTICAL_SHIFT_REGISTER_CYC =
        TMR_W'((T_VERTICAL_SHIFT_REGISTER_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [TMR_W-1:0] HD_CYC =
        TMR_W'((T_HD_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [TMR_W-1:0] FDP_CYC =
        TMR_W'((T_FDP_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [TMR_W-1:0] TMR_ONE = 8'h01;

    // ******************************************************************
    // Geometry
    // ******************************************************************
    localparam logic [9:0] PIX_SINGLE = 10'h2C4;
    localparam logic [9:0] PIX_HALF = 10'h168;
    localparam logic [8:0] CENTER_ROWS = 9'h0A4;

    // ******************************************************************
    // Register map and fields
    // ******************************************************************
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_LINES = 8'h04;
    localparam logic [7:0] ADDR_HPIX = 8'h08;
    localparam logic [7:0] ADDR_DUMP = 8'h0C;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_LCOUNT = 8'h14;
    localparam int CTRL_START = 0;
    localparam int CTRL_DUAL = 1;
    localparam int CTRL_CROW = 2;
    localparam int CTRL_CCOL = 3;
    localparam int CTRL_LONLY = 4;
    localparam int STAT_BUSY = 0;
    localparam int STAT_DONE = 1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        ST_IDLE, ST_XFER, ST_VSHIFT, ST_DUMP, ST_DUMP_WAIT, ST_HDELAY,
        ST_HSHIFT
    } seq_state_t;

endpackage : ccd_timing_pkg

// ---- hw/horiz_clock_gen.sv ----
// Horizontal phase generator with right-side phase mapping.
`timescale 1ns/100ps
module horiz_clock_gen
    import ccd_timing_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic start,
    input wire logic dual,
    input wire logic [9:0] pix_target,
    output logic horiz_phase_one,
    output logic horiz_phase_two,
    output logic right_horiz_phase_one,
    output logic right_horiz_phase_two,
    output logic pixel_reset,
    output logic busy,
    output logic done
);

    logic h1_ff;
    logic h2_ff;
    logic rst_ff;
    logic busy_ff;
    logic done_ff;
    logic [TMR_W-1:0] half_ff;
    logic [9:0] pix_ff;
    logic [9:0] tgt_ff;
    wire half_end = (half_ff == TMR_ONE);
    wire last_pix = (pix_ff == tgt_ff - 10'h001);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            h1_ff <= 1'b0;
            h2_ff <= 1'b1;
            rst_ff <= 1'b0;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
            half_ff <= '0;
            pix_ff <= '0;
            tgt_ff <= '0;
        end else if (ce) begin
            done_ff <= 1'b0;
            rst_ff <= 1'b0;
            if (!busy_ff && start) begin
                busy_ff <= 1'b1;
                tgt_ff <= pix_target;
                pix_ff <= '0;
                h1_ff <= 1'b1;
                h2_ff <= 1'b0;
                rst_ff <= 1'b1;
                half_ff <= H_HALF_CYC;
            end else if (busy_ff && !half_end) begin
                half_ff <= half_ff - TMR_ONE;
            end else if (busy_ff) begin
                // (R11) Half period floor
                half_ff <= H_HALF_CYC;
                if (h1_ff) begin
                    h1_ff <= 1'b0;
                    h2_ff <= 1'b1;
                end else if (last_pix) begin
                    busy_ff <= 1'b0;
                    done_ff <= 1'b1;
                end else begin
                    h1_ff <= 1'b1;
                    h2_ff <= 1'b0;
                    rst_ff <= 1'b1;
                    pix_ff <= pix_ff + 10'h001;
                end
            end
        end
    end

    assign horiz_phase_one = h1_ff;
    assign horiz_phase_two = h2_ff;
    // (R3) Extra right phases
    // (R4) (R5) Mode mapping
    assign right_horiz_phase_one = dual ? h1_ff : h2_ff;
    assign right_horiz_phase_two = dual ? h2_ff : h1_ff;
    assign pixel_reset = rst_ff;
    assign busy = busy_ff;
    assign done = done_ff;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_hper_high: assert property ($rose(h1_ff) |-> h1_ff[*2]) // (R11)
        else $error("Horizontal phase high shorter than floor.");
    chk_hper_low: assert property ($fell(h1_ff) |-> (!h1_ff)[*2]) // (R11)
        else $error("Horizontal phase low shorter than floor.");
    chk_right_single: assert property (!dual |-> // (R4)
        right_horiz_phase_one == h2_ff && right_horiz_phase_two == h1_ff)
        else $error("Right phases wrong in single mode.");
    chk_right_dual: assert property (dual |-> // (R5)
        right_horiz_phase_one == h1_ff && right_horiz_phase_two == h2_ff)
        else $error("Right phases wrong in dual mode.");

endmodule : horiz_clock_gen

// ---- hw/ccd_readout_timing.sv ----
// CCD readout timing generator with an AXI4-Lite control slave.
// Contract
// (R1) Single output, left amplifier: 708 horizontal shifts per line.
// (R2) Dual output: each half gets 360 horizontal shifts per line.
// (R3) Selectable output needs two extra right-side horizontal phases.
// (R4) Single mode: right phase one equals phase two, and vice versa.
// (R5) Dual mode: right phases equal the main phases one and two.
// (R6) Center vertical phases share the main signal outside center rows.
// (R7) Vertical phase one and two switch symmetrically, line and frame.
// (R8) During photodiode transfer the two vertical edges are aligned.
// (R9) Center-row mode transfers only the center 164 rows.
// (R10) A sequence reads one horizontal line without vertical transfer.
// (R11) Horizontal clock period is never below 25 ns.
// (R12) Wait at least 75 ns after a fast-dump pulse.
// (R13) Configuration selects output count and field mode for sequencing.
//
// The AXI4-Lite interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/100ps
module ccd_readout_timing
    import ccd_timing_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic vert_phase_one,
    output logic vert_phase_one_center,
    output logic vert_phase_two,
    output logic vert_phase_two_center,
    output logic vert_transfer,
    output logic vert_transfer_center,
    output logic horiz_phase_one,
    output logic horiz_phase_two,
    output logic right_horiz_phase_one,
    output logic right_horiz_phase_two,
    output logic pixel_reset,
    output logic fast_dump,
    output logic frame_busy
);

    // ******************************************************************
    // Functions
    // ******************************************************************
    function automatic logic [31:0] apply_strb(input logic [31:0] old,
        input logic [31:0] data, input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[8*i +: 8] = data[8*i +: 8];
            end
        end
        return res;
    endfunction : apply_strb

    function automatic logic mapped(input logic [7:0] addr);
        return addr == ADDR_CTRL || addr == ADDR_LINES ||
            addr == ADDR_HPIX || addr == ADDR_DUMP ||
            addr == ADDR_STATUS || addr == ADDR_LCOUNT;
    endfunction : mapped

    // ******************************************************************
    // Register bus slave
    // ******************************************************************
    logic aw_got_ff;
    logic w_got_ff;
    logic [7:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;
    logic [31:0] ctrl_ff;
    logic [31:0] lines_ff;
    logic [31:0] hpix_ff;
    logic [31:0] dump_ff;
    logic done_ff;
    logic go_ff;
    seq_state_t st_ff;
    seq_state_t nxt_st;
    logic [8:0] line_ff;

    wire aw_hs = s_axi_awvalid && s_axi_awready;
    wire w_hs = s_axi_wvalid && s_axi_wready;
    wire ar_hs = s_axi_arvalid && s_axi_arready;
    wire wr_fire = aw_got_ff && w_got_ff;
    wire busy = (st_ff != ST_IDLE) || go_ff;
    wire wr_ctrl = wr_fire && awaddr_ff == ADDR_CTRL;
    wire wr_stat = wr_fire && awaddr_ff == ADDR_STATUS;
    wire [31:0] ctrl_new = apply_strb(ctrl_ff, wdata_ff, wstrb_ff);
    wire [31:0] stat_new = apply_strb(32'h0000_0000, wdata_ff, wstrb_ff);
    wire [31:0] lines_new = apply_strb(lines_ff, wdata_ff, wstrb_ff);
    wire [31:0] hpix_new = apply_strb(hpix_ff, wdata_ff, wstrb_ff);
    wire [31:0] dump_new = apply_strb(dump_ff, wdata_ff, wstrb_ff);
    wire seq_end;
    wire [31:0] rd_mux =
        (s_axi_araddr == ADDR_CTRL) ? ctrl_ff :
        (s_axi_araddr == ADDR_LINES) ? lines_ff :
        (s_axi_araddr == ADDR_HPIX) ? hpix_ff :
        (s_axi_araddr == ADDR_DUMP) ? dump_ff :
        (s_axi_araddr == ADDR_STATUS) ?
            {30'h0, done_ff, busy} :
        (s_axi_araddr == ADDR_LCOUNT) ? {23'h0, line_ff} :
        32'h0000_0000;

    assign s_axi_awready = !aw_got_ff && !bvalid_ff;
    assign s_axi_wready = !w_got_ff && !bvalid_ff;
    assign s_axi_arready = !rvalid_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            awaddr_ff <= '0;
            wdata_ff <= '0;
            wstrb_ff <= '0;
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
        end else if (ce) begin
            if (aw_hs) begin
                aw_got_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
            end
            if (w_hs) begin
                w_got_ff <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_got_ff <= 1'b0;
                w_got_ff <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff <= mapped(awaddr_ff) ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_ff && s_axi_bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= '0;
            rresp_ff <= RESP_OKAY;
        end else if (ce) begin
            if (ar_hs) begin
                rvalid_ff <= 1'b1;
                rdata_ff <= rd_mux;
                rresp_ff <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            end else if (rvalid_ff && s_axi_rready) begin
                rvalid_ff <= 1'b0;
            end
        end
    end

    // Configuration is frozen while a sequence runs, so a frame never
    // mixes output or field modes halfway through.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_ff <= '0;
            lines_ff <= '0;
            hpix_ff <= '0;
            dump_ff <= '0;
            go_ff <= 1'b0;
        end else if (ce) begin
            go_ff <= 1'b0;
            if (wr_ctrl && !busy) begin
                ctrl_ff <= {27'h0, ctrl_new[CTRL_LONLY:CTRL_DUAL], 1'b0};
                go_ff <= ctrl_new[CTRL_START];
            end
            if (wr_fire && !busy && awaddr_ff == ADDR_LINES) begin
                lines_ff <= {23'h0, lines_new[8:0]};
            end
            if (wr_fire && !busy && awaddr_ff == ADDR_HPIX) begin
                hpix_ff <= {22'h0, hpix_new[9:0]};
            end
            if (wr_fire && !busy && awaddr_ff == ADDR_DUMP) begin
                dump_ff <= {24'h0, dump_new[7:0]};
            end
        end
    end

    // Set wins over a clear written in the same cycle.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            done_ff <= 1'b0;
        end else if (ce) begin
            done_ff <= seq_end ||
                (done_ff && !(wr_stat && stat_new[STAT_DONE]));
        end
    end

    // ******************************************************************
    // Readout sequencer
    // ******************************************************************
    wire cfg_dual = ctrl_ff[CTRL_DUAL];
    wire cfg_crow = ctrl_ff[CTRL_CROW];
    wire cfg_ccol = ctrl_ff[CTRL_CCOL];
    wire cfg_lonly = ctrl_ff[CTRL_LONLY];
    // (R9) Center rows only
    wire [8:0] lines_tgt = cfg_crow ? CENTER_ROWS :
        (lines_ff[8:0] == 9'h000) ? 9'h001 : lines_ff[8:0];
    // (R1) (R2) Line length
    wire [9:0] pix_def = cfg_dual ? PIX_HALF : PIX_SINGLE;
    wire [9:0] pix_target = (cfg_ccol && hpix_ff[9:0] != 10'h000) ?
        hpix_ff[9:0] : pix_def;

    logic [TMR_W-1:0] timer_ff;
    logic [TMR_W-1:0] nxt_timer;
    logic [7:0] dump_left_ff;
    logic v_ff;
    logic v2_ff;
    logic nxt_v;
    logic xfer_ff;
    logic nxt_xfer;
    logic fd_ff;
    logic nxt_fd;
    logic h_start;
    logic h_busy;
    logic h_done;
    logic line_step;
    wire tmr_end = (timer_ff == TMR_ONE);
    wire last_line = (line_ff + 9'h001 >= lines_tgt);

    // (R13) Mode driven sequence
    always_comb begin
        nxt_st = st_ff;
        nxt_timer = (timer_ff != '0) ? timer_ff - TMR_ONE : timer_ff;
        nxt_v = v_ff;
        nxt_xfer = xfer_ff;
        nxt_fd = fd_ff;
        h_start = 1'b0;
        line_step = 1'b0;
        unique case (st_ff)
            ST_IDLE: begin
                // (R10) Line without transfer
                if (go_ff && cfg_lonly) begin
                    nxt_st = ST_HDELAY;
                    nxt_timer = HD_CYC;
                end else if (go_ff) begin
                    nxt_st = ST_XFER;
                    nxt_timer = PD_CYC;
                    nxt_xfer = 1'b1;
                end
            end
            ST_XFER: begin
                if (tmr_end) begin
                    nxt_st = ST_VSHIFT;
                    nxt_timer = VERTICAL_SHIFT_REGISTER_CYC + VERTICAL_SHIFT_REGISTER_CYC;
                    nxt_xfer = 1'b0;
                    nxt_v = 1'b1;
                end
            end
            ST_VSHIFT: begin
                if (timer_ff == VERTICAL_SHIFT_REGISTER_CYC + TMR_ONE) begin
                    nxt_v = 1'b0;
                end
                if (tmr_end && dump_left_ff != 8'h00) begin
                    nxt_st = ST_DUMP;
                    nxt_timer = FDP_CYC;
                    nxt_fd = 1'b1;
                end else if (tmr_end) begin
                    nxt_st = ST_HDELAY;
                    nxt_timer = HD_CYC;
                end
            end
            ST_DUMP: begin
                if (tmr_end) begin
                    nxt_st = ST_DUMP_WAIT;
                    nxt_timer = FD_CYC;
                    nxt_fd = 1'b0;
                end
            end
            ST_DUMP_WAIT: begin
                // (R12) Post dump wait
                if (tmr_end) begin
                    line_step = 1'b1;
                    nxt_st = last_line ? ST_IDLE : ST_VSHIFT;
                    nxt_timer = VERTICAL_SHIFT_REGISTER_CYC + VERTICAL_SHIFT_REGISTER_CYC;
                    nxt_v = !last_line;
                end
            end
            ST_HDELAY: begin
                if (tmr_end) begin
                    nxt_st = ST_HSHIFT;
                    h_start = 1'b1;
                end
            end
            ST_HSHIFT: begin
                if (h_done) begin
                    line_step = 1'b1;
                    nxt_st = (last_line || cfg_lonly) ? ST_IDLE : ST_VSHIFT;
                    nxt_timer = VERTICAL_SHIFT_REGISTER_CYC + VERTICAL_SHIFT_REGISTER_CYC;
                    nxt_v = !(last_line || cfg_lonly);
                end
            end
        endcase
    end

    assign seq_end = line_step && (nxt_st == ST_IDLE);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_ff <= ST_IDLE;
            timer_ff <= '0;
            v_ff <= 1'b0;
            v2_ff <= 1'b1;
            xfer_ff <= 1'b0;
            fd_ff <= 1'b0;
            line_ff <= '0;
            dump_left_ff <= '0;
        end else if (ce) begin
            st_ff <= nxt_st;
            timer_ff <= nxt_timer;
            // (R7) Symmetric vertical phases
            v_ff <= nxt_v;
            v2_ff <= !nxt_v;
            xfer_ff <= nxt_xfer;
            fd_ff <= nxt_fd;
            if (st_ff == ST_IDLE && go_ff) begin
                line_ff <= '0;
                dump_left_ff <= dump_ff[7:0];
            end else if (line_step) begin
                line_ff <= line_ff + 9'h001;
            end
            if (st_ff == ST_DUMP_WAIT && tmr_end) begin
                dump_left_ff <= dump_left_ff - 8'h01;
            end
        end
    end

    horiz_clock_gen u_hgen (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .start(h_start),
        .dual(cfg_dual),
        .pix_target(pix_target),
        .horiz_phase_one(horiz_phase_one),
        .horiz_phase_two(horiz_phase_two),
        .right_horiz_phase_one(right_horiz_phase_one),
        .right_horiz_phase_two(right_horiz_phase_two),
        .pixel_reset(pixel_reset),
        .busy(h_busy),
        .done(h_done)
    );

    assign vert_phase_one = v_ff;
    assign vert_phase_two = v2_ff;
    // (R6) Shared center drive
    assign vert_phase_one_center = v_ff;
    assign vert_phase_two_center = v2_ff;
    // (R8) (R9) Transfer pulse
    assign vert_transfer = xfer_ff && !cfg_crow;
    assign vert_transfer_center = xfer_ff;
    assign fast_dump = fd_ff;
    assign frame_busy = busy;

    // ******************************************************************
    // Checks
    // ******************************************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    logic [TMR_W-1:0] xfer_len_ff;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            xfer_len_ff <= '0;
        end else if (ce) begin
            xfer_len_ff <= xfer_ff ? xfer_len_ff + TMR_ONE : '0;
        end
    end

    sequence s_go_line;
        st_ff == ST_IDLE && go_ff && cfg_lonly;
    endsequence
    sequence s_reach_hshift;
        ##[1:40] st_ff == ST_HSHIFT;
    endsequence

    chk_single_len: assert property (st_ff == ST_HSHIFT && !cfg_dual // (R1)
        && !cfg_ccol |-> pix_target == PIX_SINGLE)
        else $error("Single-output line length wrong.");
    chk_dual_len: assert property (st_ff == ST_HSHIFT && cfg_dual // (R2)
        && !cfg_ccol |-> pix_target == PIX_HALF)
        else $error("Dual-output half length wrong.");
    chk_center_tied: assert property (!cfg_crow |-> // (R6)
        vert_transfer_center == vert_transfer)
        else $error("Center transfer differs outside center rows.");
    chk_vert_symm: assert property ($changed(vert_phase_one) |-> // (R7)
        $changed(vert_phase_two) && vert_phase_one != vert_phase_two)
        else $error("Vertical phases not symmetric.");
    chk_xfer_align: assert property (xfer_ff && $past(xfer_ff) |-> // (R8)
        $stable(vert_phase_one) && $stable(vert_phase_two))
        else $error("Vertical edge inside photodiode transfer.");
    chk_xfer_len: assert property ($fell(xfer_ff) |-> // (R8)
        $past(xfer_len_ff) + TMR_ONE >= PD_CYC)
        else $error("Photodiode transfer too short.");
    chk_center_rows: assert property (cfg_crow && xfer_ff |-> // (R9)
        !vert_transfer && lines_tgt == CENTER_ROWS)
        else $error("Center-row transfer reaches outer rows.");
    chk_line_only: assert property (s_go_line |=> // (R10)
        ($stable(vert_phase_one) && !xfer_ff) throughout s_reach_hshift)
        else $error("Line-only readout moved the vertical register.");
    chk_dump_wait: assert property ($fell(fd_ff) |-> // (R12)
        (!h_busy && !h_start)[*8])
        else $error("Horizontal activity too soon after fast dump.");
    chk_mode_hold: assert property (busy && $past(busy) |-> // (R13)
        $stable(ctrl_ff))
        else $error("Mode changed during a sequence.");

endmodule : ccd_readout_timing

// ---- verif/ccd_sensor_model.sv ----
// Behavioural sensor model that counts horizontal shifts per line.
`timescale 1ns/100ps
module ccd_sensor_model (
    input wire logic aclk,
    input wire logic horiz_phase_one,
    input wire logic vert_phase_one,
    input wire logic vert_phase_one_center,
    input wire logic vert_phase_two,
    input wire logic vert_phase_two_center,
    output logic line_done,
    output logic [9:0] pix_count,
    output logic phase_fault
);
    logic h1_ff = 1'b0;
    logic [9:0] cnt_ff = 10'h000;
    logic [4:0] idle_ff = 5'h10;
    // Shift counting; a line ends after 16 quiet cycles.
    always_ff @(posedge aclk) begin
        h1_ff <= horiz_phase_one;
        line_done <= 1'b0;
        if (horiz_phase_one && !h1_ff) begin
            cnt_ff <= cnt_ff + 10'h001;
            idle_ff <= 5'h00;
        end else if (idle_ff != 5'h10) begin
            idle_ff <= idle_ff + 5'h01;
        end else if (cnt_ff != 10'h000) begin
            line_done <= 1'b1;
            pix_count <= cnt_ff;
            cnt_ff <= 10'h000;
        end
    end
    assign phase_fault = (vert_phase_one == vert_phase_two)
        || (vert_phase_one != vert_phase_one_center)
        || (vert_phase_two != vert_phase_two_center);
endmodule : ccd_sensor_model

// ---- verif/tb.sv ----
// Self-checking bench for the CCD readout timing generator.
`timescale 1ns/100ps
module tb;
    import ccd_timing_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, dual_mode = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_bvalid;
    logic s_axi_awready, s_axi_wready, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic vert_phase_one, vert_phase_one_center, vert_phase_two;
    logic vert_phase_two_center, vert_transfer, vert_transfer_center;
    logic horiz_phase_one, horiz_phase_two, right_horiz_phase_one;
    logic right_horiz_phase_two, pixel_reset, fast_dump, frame_busy;
    logic line_done, phase_fault, crow_mode = 1'b0;
    logic [9:0] pix_count;
    logic [33:0] rq[$], pq[$];
    int err_count = 0, num_checks = 0, cycles = 0, n;
    ccd_readout_timing i_ccd_readout_timing (.*);
    ccd_sensor_model i_ccd_sensor_model (.*);
    always #5 aclk = ~aclk;
    task automatic chk(input logic [33:0] seen, exp, input string what);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic end_of_test;
        if (err_count == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_of_test
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        chk({32'h0, s_axi_bresp}, {32'h0, RESP_OKAY}, "bresp");
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        @(posedge aclk);
        rq.push_back(e);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        s_axi_rready <= 1'b0;
    endtask : rd
    task automatic idle;
        do @(posedge aclk); while (frame_busy !== 1'b0);
    endtask : idle
    // Results are compared in arrival order against the noted values.
    always @(posedge aclk) begin
        if (s_axi_rvalid && s_axi_rready)
            chk({s_axi_rresp, s_axi_rdata}, rq.pop_front(), "rdata");
        if (line_done === 1'b1)
            chk({24'h0, pix_count}, pq.pop_front(), "pixels");
        if (aresetn) chk({33'h0, phase_fault}, 34'h0, "vphase");
        if (vert_transfer_center === 1'b1)
            chk(34'(vert_transfer), 34'(!crow_mode), "vxfer");
        if (fast_dump === 1'b1 || pixel_reset === 1'b1)
            chk(34'(horiz_phase_one), 34'(pixel_reset), "hclk");
        if (frame_busy === 1'b1)
            chk({32'h0, right_horiz_phase_one, right_horiz_phase_two},
                dual_mode ? {32'h0, horiz_phase_one, horiz_phase_two}
                : {32'h0, horiz_phase_two, horiz_phase_one}, "right");
        cycles++;
        if (cycles == 60000) begin
            err_count++;
            end_of_test();
        end
    end
    initial begin
        void'($urandom(32'h9F591400));
        n = 2 + $urandom % 2;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        rd(8'h18, {RESP_SLVERR, 32'h0});
        wr(ADDR_LINES, 32'(n));
        wr(ADDR_DUMP, 32'h1);
        // The dumped line shifts nothing, so only n-1 lines are seen.
        repeat (n - 1) pq.push_back(34'(PIX_SINGLE));
        wr(ADDR_CTRL, 32'h1);
        wr(ADDR_LINES, 32'h7);
        rd(ADDR_LINES, {RESP_OKAY, 32'(n)});
        idle();
        rd(ADDR_LCOUNT, {RESP_OKAY, 32'(n)});
        rd(ADDR_STATUS, {RESP_OKAY, 32'h2});
        wr(ADDR_STATUS, 32'h2);
        rd(ADDR_STATUS, {RESP_OKAY, 32'h0});
        dual_mode = 1'b1;
        pq.push_back(34'(PIX_HALF));
        wr(ADDR_CTRL, 32'h13);
        idle();
        pq.push_back(34'h5);
        wr(ADDR_HPIX, 32'h5);
        wr(ADDR_CTRL, 32'h1B);
        idle();
        // Every center row is dumped, so no line reaches the model.
        crow_mode = 1'b1;
        wr(ADDR_DUMP, 32'hFF);
        wr(ADDR_CTRL, 32'h7);
        idle();
        rd(ADDR_LCOUNT, {RESP_OKAY, 32'(CENTER_ROWS)});
        repeat (40) @(posedge aclk);
        chk(34'(pq.size()), 34'h0, "lines");
        end_of_test();
    end
endmodule : tb
